/* File: core/cra_map.vh */
// Purpose: Register offsets, flag positions, command and mode codes of the CPU register block
// Assumes: Included by the register block and its address unit
// Notes:   Definitions only
`ifndef CRA_MAP_VH
`define CRA_MAP_VH

// ==========================================================
// Register offsets (byte addresses on the APB)
`define CRA_OFF_ACC     8'h00
`define CRA_OFF_IDX1    8'h04
`define CRA_OFF_IDX2    8'h08
`define CRA_OFF_SP      8'h0c
`define CRA_OFF_PC      8'h10
`define CRA_OFF_FLAG    8'h14
`define CRA_OFF_INSN    8'h18
`define CRA_OFF_CMD     8'h1c
`define CRA_OFF_EA      8'h20
`define CRA_OFF_STAT    8'h24

// ==========================================================
// Flag register bit positions
`define CRA_F_C         0
`define CRA_F_V         1
`define CRA_F_Z         2
`define CRA_F_N         3
`define CRA_F_I         4
`define CRA_F_H         5
`define CRA_F_X         6
`define CRA_F_S         7

// ==========================================================
// Reset values
`define CRA_FLAG_RST    8'hd0
`define CRA_SP_RST      16'h00ff
`define CRA_PC_RST      16'h0000

// ==========================================================
// Command codes (CMD[3:0])
`define CRA_OP_NOP      4'h0
`define CRA_OP_DECODE   4'h1
`define CRA_OP_ALU      4'h2
`define CRA_OP_PUSH     4'h3
`define CRA_OP_PULL     4'h4
`define CRA_OP_BRANCH   4'h5
`define CRA_OP_TAP      4'h6
`define CRA_OP_RETURN   4'h7
`define CRA_OP_STOP     4'h8

// ==========================================================
// Addressing modes (CMD[6:4])
`define CRA_M_IMM       3'h0
`define CRA_M_DIR       3'h1
`define CRA_M_EXT       3'h2
`define CRA_M_IDX       3'h3
`define CRA_M_INH       3'h4
`define CRA_M_REL       3'h5

// ==========================================================
// ALU selections (CMD[19:16])
`define CRA_A_ADD       4'h0
`define CRA_A_ADC       4'h1
`define CRA_A_SUB       4'h2
`define CRA_A_AND       4'h3
`define CRA_A_ASL       4'h4
`define CRA_A_ADDAB     4'h5
`define CRA_A_ADDD      4'h6
`define CRA_A_LDA       4'h7

// ==========================================================
// Prebytes and opcode pages
`define CRA_PRE_P2      8'h18
`define CRA_PRE_P3      8'h1a
`define CRA_PRE_P4      8'hcd
`define CRA_PG1         2'h0
`define CRA_PG2         2'h1
`define CRA_PG3         2'h2
`define CRA_PG4         2'h3
`define CRA_DIR_HI      8'h00

`endif

/* File: core/cra_addr.v */
// Purpose: Effective-address and instruction-length former
// Assumes: Instruction bytes packed low byte first, prebyte if any in byte 0
// Notes:   Purely combinational
`timescale 1ns/1ns
`default_nettype none
`include "cra_map.vh"

module cra_addr (
	// Instruction and mode
	input  wire [31:0] insn,
	input  wire [2:0]  mode,
	input  wire        wide,
	// Register state
	input  wire [15:0] idx1,
	input  wire [15:0] idx2,
	input  wire [15:0] pc,
	// Results
	output reg  [15:0] ea,
	output reg  [1:0]  page,
	output reg  [2:0]  len,
	output reg         mem_ref,
	output wire        extra_cyc
);
	wire       pre;
	wire [7:0] b1;
	wire [7:0] b2;
	wire [2:0] o;

	// ==========================================================
	// Prebyte decode
	assign pre       = (insn[7:0] == `CRA_PRE_P2) || (insn[7:0] == `CRA_PRE_P3) ||
	                   (insn[7:0] == `CRA_PRE_P4);
	assign extra_cyc = pre;
	assign o         = pre ? 3'h1 : 3'h0;
	assign b1        = pre ? insn[23:16] : insn[15:8];
	assign b2        = pre ? insn[31:24] : insn[23:16];

	// ==========================================================
	// Address formation
	always @* begin
		case (insn[7:0])
			`CRA_PRE_P2: page = `CRA_PG2;
			`CRA_PRE_P3: page = `CRA_PG3;
			`CRA_PRE_P4: page = `CRA_PG4;
			default:     page = `CRA_PG1;
		endcase
		mem_ref = 1'b1;
		case (mode)
			`CRA_M_IMM: begin
				ea  = pc + {13'h0, o} + 16'h0001;
				len = o + (wide ? 3'h3 : 3'h2);
			end
			`CRA_M_DIR: begin
				ea  = {`CRA_DIR_HI, b1};
				len = o + 3'h2;
			end
			`CRA_M_EXT: begin
				ea  = {b1, b2};
				len = o + 3'h3;
			end
			`CRA_M_IDX: begin
				// 16-bit sum wraps past the top of memory
				ea  = ((page == `CRA_PG2) ? idx2 : idx1) + {8'h00, b1};
				len = o + 3'h2;
			end
			`CRA_M_REL: begin
				ea  = pc + {13'h0, o} + 16'h0002 + {{8{b1[7]}}, b1};
				len = o + 3'h2;
			end
			default: begin
				ea      = 16'h0000;
				len     = o + 3'h1;
				mem_ref = 1'b0;
			end
		endcase
	end
endmodule
`default_nettype wire

/* File: core/cra_regs.v */
// Purpose: Programmer-visible CPU registers, flags and operand addressing behind APB
// Assumes: Single-master APB, pclk at 10 MHz, memory bus answers reads in the cycle the read strobe is high
// Notes:   Commands written to CMD act in the access cycle of that write
`timescale 1ns/1ns
`default_nettype none
`include "cra_map.vh"

module cra_regs (
	// Clock and reset
	input  wire        pclk,
	input  wire        presetn,
	// APB slave
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [7:0]  paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output reg         pready,
	output reg         pslverr,
	// Internal memory bus
	output reg  [15:0] mem_addr_q,
	output reg  [7:0]  mem_wdata_q,
	output reg         mem_wr_q,
	output reg         mem_rd_q,
	input  wire [7:0]  mem_rdata,
	// Interrupt pins and events
	input  wire        irq_req_n,
	input  wire        nonmaskable_interrupt_input_n,
	output reg         irq_ack_q,
	output reg         nmi_ack_q,
	output reg         stop_q
);
	// ==========================================================
	// State
	reg  [15:0] acc_q;
	reg  [15:0] idx1_q;
	reg  [15:0] idx2_q;
	reg  [15:0] sp_q;
	reg  [15:0] pc_q;
	reg  [7:0]  flag_q;
	reg  [31:0] insn_q;
	reg  [15:0] ea_q;
	reg  [1:0]  page_q;
	reg  [2:0]  len_q;
	reg         extra_q;
	reg         mref_q;
	reg         pull_pend_q;
	reg  [1:0]  irq_sync_q;
	reg  [2:0]  nmi_sync_q;

	wire        acc_wr;
	wire        acc_rd;
	wire        cmd_go;
	wire [3:0]  op;
	wire [2:0]  cmd_mode;
	wire [2:0]  eff_mode;
	wire [7:0]  opnd;
	wire [15:0] opnd16;
	wire [3:0]  alu_sel;
	wire [2:0]  cond_sel;
	wire        cond_pol;
	wire [15:0] ea_w;
	wire [1:0]  page_w;
	wire [2:0]  len_w;
	wire        mref_w;
	wire        extra_w;
	wire        nmi_fall;
	wire        irq_live;

	// ==========================================================
	// APB decode
	assign acc_wr   = psel & penable & pready & pwrite;
	assign acc_rd   = psel & ~penable & ~pwrite;
	assign cmd_go   = acc_wr & (paddr == `CRA_OFF_CMD);
	assign op       = pwdata[3:0];
	assign cmd_mode = pwdata[6:4];
	assign opnd     = pwdata[15:8];
	assign opnd16   = {pwdata[15:8], pwdata[31:24]};
	assign alu_sel  = pwdata[19:16];
	assign cond_sel = pwdata[22:20];
	assign cond_pol = pwdata[23];
	assign eff_mode = (op == `CRA_OP_BRANCH) ? `CRA_M_REL : cmd_mode;

	// ==========================================================
	// Address former
	cra_addr u_addr (
		.insn      (insn_q),
		.mode      (eff_mode),
		.wide      (pwdata[7]),
		.idx1      (idx1_q),
		.idx2      (idx2_q),
		.pc        (pc_q),
		.ea        (ea_w),
		.page      (page_w),
		.len       (len_w),
		.mem_ref   (mref_w),
		.extra_cyc (extra_w)
	);

	// ==========================================================
	// Pin synchronisers
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_sync_q <= 2'h3;
			nmi_sync_q <= 3'h7;
		end else begin
			irq_sync_q <= {irq_sync_q[0], irq_req_n};
			nmi_sync_q <= {nmi_sync_q[1:0], nonmaskable_interrupt_input_n};
		end
	end
	assign nmi_fall = nmi_sync_q[2] & ~nmi_sync_q[1] & ~flag_q[`CRA_F_X];
	assign irq_live = ~irq_sync_q[1] & ~flag_q[`CRA_F_I];

	// ==========================================================
	// ALU
	reg  [7:0]  a_in;
	reg  [7:0]  m_in;
	reg  [8:0]  sum9;
	reg  [16:0] sum17;
	reg  [15:0] res;
	reg         wide_res;
	reg         c_n;
	reg         v_n;
	reg         h_n;
	reg         h_upd;
	reg         c_upd;
	reg         cond_ok;
	reg         cflag;

	always @* begin
		a_in     = acc_q[15:8];
		m_in     = (alu_sel == `CRA_A_ADDAB) ? acc_q[7:0] : opnd;
		cflag    = flag_q[`CRA_F_C];
		sum9     = 9'h000;
		sum17    = 17'h00000;
		res      = 16'h0000;
		wide_res = 1'b0;
		c_n      = cflag;
		v_n      = 1'b0;
		h_n      = flag_q[`CRA_F_H];
		h_upd    = 1'b0;
		c_upd    = 1'b1;
		case (alu_sel)
			`CRA_A_ADD, `CRA_A_ADC, `CRA_A_ADDAB: begin
				sum9  = {1'b0, a_in} + {1'b0, m_in} +
				        {8'h00, (alu_sel == `CRA_A_ADC) & cflag};
				res   = {8'h00, sum9[7:0]};
				c_n   = sum9[8];
				v_n   = (a_in[7] & m_in[7] & ~sum9[7]) | (~a_in[7] & ~m_in[7] & sum9[7]);
				h_n   = (a_in[3] & m_in[3]) | (m_in[3] & ~sum9[3]) | (~sum9[3] & a_in[3]);
				h_upd = 1'b1;
			end
			`CRA_A_SUB: begin
				sum9 = {1'b0, a_in} - {1'b0, m_in};
				res  = {8'h00, sum9[7:0]};
				c_n  = sum9[8];
				v_n  = (a_in[7] & ~m_in[7] & ~sum9[7]) | (~a_in[7] & m_in[7] & sum9[7]);
			end
			`CRA_A_AND: begin
				res   = {8'h00, a_in & m_in};
				c_upd = 1'b0;
			end
			`CRA_A_ASL: begin
				res = {8'h00, a_in[6:0], 1'b0};
				c_n = a_in[7];
				v_n = a_in[7] ^ a_in[6];
			end
			`CRA_A_ADDD: begin
				sum17    = {1'b0, acc_q} + {1'b0, opnd16};
				res      = sum17[15:0];
				wide_res = 1'b1;
				c_n      = sum17[16];
				v_n      = (acc_q[15] & opnd16[15] & ~sum17[15]) |
				           (~acc_q[15] & ~opnd16[15] & sum17[15]);
			end
			default: begin
				res   = {8'h00, m_in};
				c_upd = 1'b0;
			end
		endcase
		if (!c_upd)
			c_n = cflag;
		case (cond_sel)
			3'h1:    cond_ok = flag_q[`CRA_F_C] == cond_pol;
			3'h2:    cond_ok = flag_q[`CRA_F_Z] == cond_pol;
			3'h3:    cond_ok = flag_q[`CRA_F_N] == cond_pol;
			3'h4:    cond_ok = flag_q[`CRA_F_V] == cond_pol;
			default: cond_ok = 1'b1;
		endcase
	end

	// ==========================================================
	// CPU state and commands
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			acc_q       <= 16'h0000;
			idx1_q      <= 16'h0000;
			idx2_q      <= 16'h0000;
			sp_q        <= `CRA_SP_RST;
			pc_q        <= `CRA_PC_RST;
			flag_q      <= `CRA_FLAG_RST;
			insn_q      <= 32'h00000000;
			ea_q        <= 16'h0000;
			page_q      <= `CRA_PG1;
			len_q       <= 3'h0;
			extra_q     <= 1'b0;
			mref_q      <= 1'b0;
			pull_pend_q <= 1'b0;
			mem_addr_q  <= 16'h0000;
			mem_wdata_q <= 8'h00;
			mem_wr_q    <= 1'b0;
			mem_rd_q    <= 1'b0;
			irq_ack_q   <= 1'b0;
			nmi_ack_q   <= 1'b0;
			stop_q      <= 1'b0;
		end else begin
			mem_wr_q    <= 1'b0;
			mem_rd_q    <= 1'b0;
			irq_ack_q   <= 1'b0;
			nmi_ack_q   <= 1'b0;
			pull_pend_q <= 1'b0;
			if (pull_pend_q)
				acc_q[15:8] <= mem_rdata;
			if (acc_wr) begin
				case (paddr)
					`CRA_OFF_ACC:  acc_q  <= pwdata[15:0];
					`CRA_OFF_IDX1: idx1_q <= pwdata[15:0];
					`CRA_OFF_IDX2: idx2_q <= pwdata[15:0];
					`CRA_OFF_SP:   sp_q   <= pwdata[15:0];
					`CRA_OFF_PC:   pc_q   <= pwdata[15:0];
					`CRA_OFF_FLAG: flag_q <= {pwdata[7], flag_q[`CRA_F_X], pwdata[5:0]};
					`CRA_OFF_INSN: insn_q <= pwdata;
					default: ;
				endcase
			end
			if (cmd_go) begin
				case (op)
					`CRA_OP_DECODE: begin
						ea_q    <= ea_w;
						page_q  <= page_w;
						len_q   <= len_w;
						extra_q <= extra_w;
						mref_q  <= mref_w;
						pc_q    <= pc_q + {13'h0, len_w};
					end
					`CRA_OP_ALU: begin
						if (wide_res)
							acc_q <= res;
						else
							acc_q[15:8] <= res[7:0];
						flag_q[`CRA_F_C] <= c_n;
						flag_q[`CRA_F_V] <= v_n;
						flag_q[`CRA_F_Z] <= wide_res ? (res == 16'h0000) : (res[7:0] == 8'h00);
						flag_q[`CRA_F_N] <= wide_res ? res[15] : res[7];
						if (h_upd)
							flag_q[`CRA_F_H] <= h_n;
					end
					`CRA_OP_PUSH: begin
						mem_addr_q  <= sp_q;
						mem_wdata_q <= acc_q[15:8];
						mem_wr_q    <= 1'b1;
						sp_q        <= sp_q - 16'h0001;
					end
					`CRA_OP_PULL: begin
						mem_addr_q  <= sp_q + 16'h0001;
						mem_rd_q    <= 1'b1;
						pull_pend_q <= 1'b1;
						sp_q        <= sp_q + 16'h0001;
					end
					`CRA_OP_BRANCH: begin
						ea_q  <= ea_w;
						len_q <= len_w;
						pc_q  <= cond_ok ? ea_w : pc_q + {13'h0, len_w};
					end
					`CRA_OP_TAP:
						flag_q <= {acc_q[15], acc_q[14] & flag_q[`CRA_F_X], acc_q[13:8]};
					`CRA_OP_RETURN:
						flag_q <= {opnd[7], opnd[6] & flag_q[`CRA_F_X], opnd[5:0]};
					`CRA_OP_STOP:
						if (!flag_q[`CRA_F_S])
							stop_q <= 1'b1;
					default: ;
				endcase
			end
			// Hardware mask sets come last so they win over any write
			if (irq_live) begin
				flag_q[`CRA_F_I] <= 1'b1;
				irq_ack_q        <= 1'b1;
				stop_q           <= 1'b0;
			end
			if (nmi_fall) begin
				flag_q[`CRA_F_X] <= 1'b1;
				flag_q[`CRA_F_I] <= 1'b1;
				nmi_ack_q        <= 1'b1;
				stop_q           <= 1'b0;
			end
		end
	end

	// ==========================================================
	// APB answer: one access cycle, read data registered in setup
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata  <= 32'h00000000;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready  <= psel & ~penable;
			pslverr <= psel & ~penable & (paddr > `CRA_OFF_STAT || paddr[1:0] != 2'h0);
			if (acc_rd) begin
				case (paddr)
					`CRA_OFF_ACC:  prdata <= {16'h0000, acc_q};
					`CRA_OFF_IDX1: prdata <= {16'h0000, idx1_q};
					`CRA_OFF_IDX2: prdata <= {16'h0000, idx2_q};
					`CRA_OFF_SP:   prdata <= {16'h0000, sp_q};
					`CRA_OFF_PC:   prdata <= {16'h0000, pc_q};
					`CRA_OFF_FLAG: prdata <= {24'h000000, flag_q};
					`CRA_OFF_INSN: prdata <= insn_q;
					`CRA_OFF_EA:   prdata <= {9'h000, mref_q, extra_q, len_q, page_q, ea_q};
					`CRA_OFF_STAT: prdata <= {29'h0, stop_q, ~irq_sync_q[1], ~nmi_sync_q[1]};
					default:       prdata <= 32'h00000000;
				endcase
			end else if (psel & ~penable) begin
				prdata <= 32'h00000000;
			end
		end
	end
endmodule
`default_nettype wire

/* File: verification/cra_regs_props.sv */
// Purpose: Port-level checks of the CPU register block
// Assumes: Bound to cra_regs, one clock domain
// Notes:   Stack check remembers the last push address
`timescale 1ns/1ns
`default_nettype none
module cra_regs_props (
	// Clock and reset
	input wire logic        pclk,
	input wire logic        presetn,
	// APB
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic        pready,
	input wire logic        pslverr,
	// Internal bus
	input wire logic [15:0] mem_addr_q,
	input wire logic        mem_wr_q,
	input wire logic        mem_rd_q,
	// Interrupts and stop
	input wire logic        irq_req_n,
	input wire logic        nonmaskable_interrupt_input_n,
	input wire logic        irq_ack_q,
	input wire logic        nmi_ack_q,
	input wire logic        stop_q
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// ==========================================================
	// Helper: address of the last push not yet pulled
	logic [15:0] top_q;
	logic        pushed_q;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			top_q <= 16'h0000;
			pushed_q <= 1'b0;
		end else if (mem_wr_q) begin
			top_q <= mem_addr_q;
			pushed_q <= 1'b1;
		end else if (mem_rd_q) begin
			pushed_q <= 1'b0;
		end
	end
	// ==========================================================
	// Assertions
	sequence s_setup;
		psel && !penable;
	endsequence
	sequence s_cmd_write;
		pready && pwrite && paddr == 8'h1c;
	endsequence
	a_ready_next: assert property (s_setup |=> pready)
		else $error("no answer after setup");
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("answer longer than one cycle");
	a_err_map: assert property (pready |-> pslverr == (paddr > 8'h24 || paddr[1:0] != 2'h0))
		else $error("error flag wrong for address");
	a_push_pulse: assert property (mem_wr_q |=> !mem_wr_q)
		else $error("push strobe too long");
	a_stack_lifo: assert property (mem_rd_q && pushed_q |-> mem_addr_q == top_q)
		else $error("pull address differs from last push");
	a_stop_cause: assert property ($rose(stop_q) |-> $past(pready && pwrite && paddr == 8'h1c))
		else $error("stop without command");
	a_irq_cause: assert property (irq_ack_q |-> !$past(irq_req_n, 2) || !$past(irq_req_n, 3))
		else $error("interrupt taken without request");
	a_irq_once: assert property (irq_ack_q |=> !irq_ack_q [*2])
		else $error("interrupt taken twice");
	a_nmi_cause: assert property (nmi_ack_q |-> !$past(nonmaskable_interrupt_input_n, 2)
		|| !$past(nonmaskable_interrupt_input_n, 3))
		else $error("nonmaskable taken without request");
	c_cmd: cover property (s_cmd_write);
endmodule
bind cra_regs cra_regs_props cra_regs_props_inst (.pclk, .presetn, .psel, .penable, .pwrite,
	.paddr, .pready, .pslverr, .mem_addr_q, .mem_wr_q, .mem_rd_q, .irq_req_n,
	.nonmaskable_interrupt_input_n, .irq_ack_q, .nmi_ack_q, .stop_q);
`default_nettype wire

/* File: verification/cra_mem.sv */
// Purpose: Memory on the internal bus
// Assumes: Read data is needed in the cycle the read strobe is high
// Notes:   Released data line shows a changing pattern
`timescale 1ns/1ns
`default_nettype none
module cra_mem (
	// Clock
	input wire logic        pclk,
	// Internal bus
	input wire logic [15:0] mem_addr,
	input wire logic [7:0]  mem_wdata,
	input wire logic        mem_wr,
	input wire logic        mem_rd,
	output wire logic [7:0] mem_rdata
);
	logic [7:0] store [0:65535];
	logic [7:0] junk_q = 8'ha5;
	assign mem_rdata = mem_rd ? store[mem_addr] : junk_q;
	always @(posedge pclk) begin
		junk_q <= ~junk_q;
		if (mem_wr)
			store[mem_addr] <= mem_wdata;
	end
endmodule
`default_nettype wire

/* File: verification/tb.sv */
// Purpose: Self-checking bench of the CPU register block
// Assumes: APB answers in one access cycle; bench still waits for pready
// Notes:   Tests are sequences of register accesses
`timescale 1ns/1ns
`default_nettype none
`include "cra_map.vh"
module tb;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic [31:0] rdat;
	logic        pready;
	logic        pslverr;
	logic        rerr;
	logic [15:0] mem_addr;
	logic [7:0]  mem_wdata;
	logic [7:0]  mem_rdata;
	logic        mem_wr;
	logic        mem_rd;
	logic        irq_n = 1'b1;
	logic        nmi_n = 1'b1;
	logic        irq_ack;
	logic        nmi_ack;
	logic        stop;
	int          err_count = 0;
	int          n_compared = 0;
	int          n_irq = 0;
	int          n_nmi = 0;
	always #50 pclk = ~pclk;
	always @(posedge pclk) begin
		n_irq += int'(irq_ack === 1'b1);
		n_nmi += int'(nmi_ack === 1'b1);
	end
	cra_regs cra_regs_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .mem_addr_q(mem_addr), .mem_wdata_q(mem_wdata),
		.mem_wr_q(mem_wr), .mem_rd_q(mem_rd), .mem_rdata, .irq_req_n(irq_n),
		.nonmaskable_interrupt_input_n(nmi_n), .irq_ack_q(irq_ack), .nmi_ack_q(nmi_ack),
		.stop_q(stop));
	cra_mem cra_mem_inst (.pclk, .mem_addr, .mem_wdata, .mem_wr, .mem_rd, .mem_rdata);
	// ==========================================================
	// Bus and compare tasks
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			$display("wrong value %s exp %h got %h", s, e, g);
			err_count++;
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rd(input logic [7:0] a, input string s, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(s, e, rdat);
	endtask
	task automatic alu(input logic [7:0] f, input logic [15:0] acc, input logic [3:0] op,
		input logic [15:0] v, input logic [15:0] ea, input logic [7:0] ef);
		wr(8'h14, {24'h0, f});
		wr(8'h00, {16'h0, acc});
		wr(8'h1c, {v[7:0], 4'h0, op, v[15:8], 8'h02});
		rd(8'h00, "acc", {16'h0, ea});
		rd(8'h14, "flags", {24'h0, ef});
	endtask
	task automatic dec(input logic [31:0] ins, input logic [3:0] md, input logic [15:0] ea,
		input logic [1:0] pg, input logic [2:0] ln);
		wr(8'h10, 32'h1000);
		wr(8'h18, ins);
		wr(8'h1c, {24'h0, md, 4'h1});
		apb(1'b0, 8'h20, 32'h0);
		chk("ea", {10'h0, pg != 2'h0, ln, pg, ea}, {10'h0, rdat[21:0]});
		chk("memref", {31'h0, md[2:0] != 3'h4}, {31'h0, rdat[22]});
		rd(8'h10, "pc", 32'h1000 + {29'h0, ln});
	endtask
	task automatic br(input logic [31:0] cmd, input logic [15:0] pc);
		wr(8'h10, 32'h1000);
		wr(8'h1c, cmd);
		rd(8'h10, "pc", {16'h0, pc});
	endtask
	task automatic results;
		$display("compared %0d mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	initial begin
		#3000000;
		err_count++;
		results();
	end
	// ==========================================================
	// Tests
	initial begin
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		rd(8'h0c, "sp", {16'h0, `CRA_SP_RST});
		rd(8'h10, "pc", {16'h0, `CRA_PC_RST});
		rd(8'h14, "flags", {24'h0, `CRA_FLAG_RST});
		apb(1'b0, 8'h28, 32'h0);
		chk("slverr", 32'h1, {31'h0, rerr});
		chk("unmapped read", 32'h0, rdat);
		apb(1'b0, 8'h05, 32'h0);
		chk("slverr", 32'h1, {31'h0, rerr});
		$display("test reset done");
		alu(8'hd0, 16'h0800, 4'h0, 16'h0800, 16'h1000, 8'hf0);
		alu(8'hd0, 16'h8000, 4'h0, 16'h8000, 16'h0000, 8'hd7);
		alu(8'hd0, 16'h0000, 4'h2, 16'h0100, 16'hff00, 8'hd9);
		alu(8'hd0, 16'h8000, 4'h2, 16'h0100, 16'h7f00, 8'hd2);
		alu(8'hd1, 16'hf000, 4'h3, 16'h8000, 16'h8000, 8'hd9);
		alu(8'hd0, 16'hc000, 4'h4, 16'h0000, 16'h8000, 8'hd9);
		alu(8'hd1, 16'h0f00, 4'h1, 16'h0000, 16'h1000, 8'hf0);
		alu(8'hd0, 16'h7f01, 4'h5, 16'h0000, 16'h8001, 8'hfa);
		alu(8'hd1, 16'h5500, 4'h7, 16'h0000, 16'h0000, 8'hd5);
		alu(8'hd0, 16'h12ff, 4'h6, 16'h0001, 16'h1300, 8'hd0);
		$display("test alu done");
		wr(8'h04, 32'hfff0);
		wr(8'h08, 32'h2000);
		dec(32'h00000034 << 8 | 32'h86, 4'h0, 16'h1001, 2'h0, 3'h2);
		dec(32'h003412cc, 4'h8, 16'h1001, 2'h0, 3'h3);
		dec(32'h00348618, 4'h0, 16'h1002, 2'h1, 3'h3);
		dec(32'h0000ff96, 4'h1, 16'h00ff, 2'h0, 3'h2);
		dec(32'h0080961a, 4'h1, 16'h0080, 2'h2, 3'h3);
		dec(32'h003412b6, 4'h2, 16'h1234, 2'h0, 3'h3);
		dec(32'h000020a6, 4'h3, 16'h0010, 2'h0, 3'h2);
		dec(32'h00ffa618, 4'h3, 16'h20ff, 2'h1, 3'h3);
		dec(32'h0005a6cd, 4'h3, 16'hfff5, 2'h3, 3'h3);
		dec(32'h0000004f, 4'h4, 16'h0000, 2'h0, 3'h1);
		$display("test addressing done");
		wr(8'h18, 32'h0000f020);
		wr(8'h14, 32'h00d0);
		br(32'h00000055, 16'h0ff2);
		br(32'h00900055, 16'h1002);
		br(32'h00100055, 16'h0ff2);
		br(32'h00a00055, 16'h1002);
		br(32'h00300055, 16'h0ff2);
		br(32'h00c00055, 16'h1002);
		$display("test branch done");
		wr(8'h0c, 32'h0200);
		wr(8'h00, 32'h5a00);
		wr(8'h1c, 32'h3);
		rd(8'h0c, "sp", 32'h01ff);
		wr(8'h00, 32'h0);
		wr(8'h1c, 32'h4);
		rd(8'h00, "acc", 32'h5a00);
		rd(8'h0c, "sp", 32'h0200);
		$display("test stack done");
		wr(8'h14, 32'h0);
		rd(8'h14, "flags", 32'h40);
		wr(8'h00, 32'h0);
		wr(8'h1c, 32'h6);
		rd(8'h14, "flags", 32'h0);
		nmi_n <= 1'b0;
		repeat (10) @(posedge pclk);
		nmi_n <= 1'b1;
		chk("nmi acks", 32'h1, n_nmi);
		rd(8'h14, "flags", 32'h50);
		wr(8'h1c, 32'h7);
		rd(8'h14, "flags", 32'h0);
		wr(8'h14, 32'h80);
		wr(8'h1c, 32'h8);
		@(posedge pclk);
		chk("stop", 32'h0, {31'h0, stop});
		wr(8'h14, 32'h0);
		wr(8'h1c, 32'h8);
		@(posedge pclk);
		chk("stop", 32'h1, {31'h0, stop});
		irq_n <= 1'b0;
		repeat (10) @(posedge pclk);
		chk("irq acks", 32'h1, n_irq);
		chk("stop", 32'h0, {31'h0, stop});
		rd(8'h14, "flags", 32'h10);
		rd(8'h24, "status", 32'h2);
		repeat (10) @(posedge pclk);
		chk("irq acks", 32'h1, n_irq);
		irq_n <= 1'b1;
		$display("test interrupts done");
		results();
	end
endmodule
`default_nettype wire
